// file: rtl/dfp_chan.sv
// one channel: sinc3 plus sinc1 cascade and fast-settling sinc1 path
`timescale 1ns/1ps
module dfp_chan import dfp_pkg::*; (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    dfp_chan_if.chan  cif
);
    logic [CIC_W-1:0] i1, i2, i3, d1, d2, d3;
    logic [CIC_W-1:0] next_i1, next_i2, next_i3, next_d1, next_d2, next_d3;
    logic [CIC_W-1:0] c1, c2, c3;
    logic [ACC_W-1:0] acc, next_acc, sum;
    logic [3:0]       cnt1, next_cnt1;
    logic [FAC_W-1:0] facc, next_facc;
    logic [1:0]       conv, next_conv;
    logic [RES_W-1:0] res, next_res;
    logic             vld, next_vld;
    logic [NRM_W-1:0] s3n, outn, fastn;
    logic [3:0]       ktot;
    logic [4:0]       sh3, shf;
    logic             last;

    // offset-binary density to two's complement, top code saturates
    function automatic logic [RES_W-1:0] to_code(input logic [NRM_W-1:0] u);
        logic [32:0] s;
        s = {2'b00, u} - RES_MID;
        if (!s[32] && s[29]) begin
            return 24'h7FFFFF;
        end
        return s[29:RES_SH];
    endfunction

    // integrate every tick, comb at window end, sinc1 over 2^k1 words
    always_comb begin
        next_i1 = i1;
        next_i2 = i2;
        next_i3 = i3;
        next_d1 = d1;
        next_d2 = d2;
        next_d3 = d3;
        next_acc = acc;
        next_cnt1 = cnt1;
        next_facc = facc;
        next_conv = conv;
        next_res = res;
        next_vld = 1'b0;
        ktot = cif.k3 + {1'b0, cif.k1};
        sh3 = NRM_TOP - ({1'b0, cif.k3} + {cif.k3, 1'b0});
        shf = NRM_TOP - {1'b0, ktot};
        c1 = i3 - d1;
        c2 = c1 - d2;
        c3 = c2 - d3;
        s3n = NRM_W'(c3 << sh3);                        // scale so N cubed maps to 2^30
        sum = acc + ACC_W'(s3n);
        last = (cnt1 == 4'((5'h01 << cif.k1) - 5'h01));
        outn = NRM_W'(sum >> cif.k1);
        fastn = NRM_W'({16'h0000, facc} << shf);
        if (cif.restart) begin
            next_i1 = '0;
            next_i2 = '0;
            next_i3 = '0;
            next_d1 = '0;
            next_d2 = '0;
            next_d3 = '0;
            next_acc = '0;
            next_cnt1 = '0;
            next_facc = '0;
        end else if (cif.tick) begin
            // both paths see the same bitstream
            next_i1 = i1 + CIC_W'(cif.bit_in);
            next_i2 = i2 + i1;
            next_i3 = i3 + i2;
            next_facc = facc + FAC_W'(cif.bit_in);
            if (cif.win_end) begin
                next_d1 = i3;
                next_d2 = c1;
                next_d3 = c2;
                if (last) begin
                    next_acc = '0;
                    next_cnt1 = '0;
                    next_facc = FAC_W'(cif.bit_in);
                    next_vld = 1'b1;                    // never gated
                    if (conv < FAST_CONV) begin
                        next_res = to_code(fastn);
                        next_conv = conv + 2'h1;
                    end else begin
                        next_res = to_code(outn);
                    end
                end else begin
                    next_acc = sum;
                    next_cnt1 = cnt1 + 4'h1;
                end
            end
        end
    end

    // conversion count survives restarts, only reset clears it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            i1 <= '0;
            i2 <= '0;
            i3 <= '0;
            d1 <= '0;
            d2 <= '0;
            d3 <= '0;
            acc <= '0;
            cnt1 <= '0;
            facc <= '0;
            conv <= '0;
            res <= '0;
            vld <= 1'b0;
        end else begin
            i1 <= next_i1;
            i2 <= next_i2;
            i3 <= next_i3;
            d1 <= next_d1;
            d2 <= next_d2;
            d3 <= next_d3;
            acc <= next_acc;
            cnt1 <= next_cnt1;
            facc <= next_facc;
            conv <= next_conv;
            res <= next_res;
            vld <= next_vld;
        end
    end

    assign cif.result = res;
    assign cif.valid = vld;
    assign cif.fast_sel = (conv < FAST_CONV);
endmodule // dfp_chan

// file: rtl/dfp_chan_if.sv
// carrier between the control logic and one filter channel
`timescale 1ns/1ps
interface dfp_chan_if;
    import dfp_pkg::*;
    logic             tick;
    logic             bit_in;
    logic             restart;
    logic             win_end;
    logic [3:0]       k3;
    logic [2:0]       k1;
    logic [RES_W-1:0] result;
    logic             valid;
    logic             fast_sel;
    modport ctrl (output tick, bit_in, restart, win_end, k3, k1,
                  input result, valid, fast_sel);
    modport chan (input tick, bit_in, restart, win_end, k3, k1,
                  output result, valid, fast_sel);
endinterface

// file: rtl/dfp_pkg.sv
// constants shared by the decimation filter block
package dfp_pkg;
    localparam int MAX_CH = 4;              // address map holds four channels
    localparam int PH_W   = 10;             // phase offset width
    localparam int CIC_W  = 32;             // sinc3 register width, 3*10+1 needed
    localparam int NRM_W  = 31;             // normalised full scale is 2^30
    localparam int RES_W  = 24;
    localparam int ACC_W  = 36;             // sinc1 sum of up to 16 words
    localparam int FAC_W  = 15;             // fast path count up to 16384
    localparam int SET_W  = 16;
    localparam int RES_SH = 6;              // 30-bit value down to 24 bits

    localparam logic [3:0] LG_FAST  = 4'h6; // fast rate gives osr 64
    localparam logic [3:0] LG_BASE  = 4'h7; // osr code 0 gives 128
    localparam logic [3:0] LG_S3MAX = 4'hA; // sinc3 stops at 1024
    localparam logic [4:0] NRM_TOP  = 5'h1E;
    localparam logic [1:0] FAST_CONV = 2'h2; // results taken from fast path
    localparam logic [32:0] RES_MID = 33'h0_2000_0000;

    // settling in main clocks: sinc3 part, block, tail
    localparam logic [SET_W-1:0] SET_TAIL  = 16'h0030;
    localparam logic [SET_W-1:0] SET_S3MUL = 16'h0003;
    localparam logic [SET_W-1:0] SET_BLK   = 16'h0400;
    localparam logic [SET_W-1:0] SET_ADD2  = 16'h0002;

    // main clocks per modulator cycle for divider codes 00b..11b
    localparam logic [3:0] DIV_R0 = 4'h2;
    localparam logic [3:0] DIV_R1 = 4'h4;
    localparam logic [3:0] DIV_R2 = 4'h8;
    localparam logic [3:0] DIV_R3 = 4'hC;

    // register byte addresses
    localparam logic [7:0] A_CLK   = 8'h00;
    localparam logic [7:0] A_STAT  = 8'h04;
    localparam logic [7:0] A_RSYNC = 8'h08;
    localparam logic [7:0] A_CFG0  = 8'h10;
    localparam logic [7:0] A_RES0  = 8'h20;
    localparam logic [7:0] A_STEP  = 8'h04;

    // field positions
    localparam int F_OSR = 0;
    localparam int F_FAST = 3;
    localparam int F_DIV = 4;
    localparam int F_EN = 8;
    localparam int F_RSYNC = 0;
    localparam int F_PH = 0;
    localparam int F_MUX = 10;
    localparam int F_GAIN = 12;
    localparam int F_SETL = 0;
    localparam int F_FSEL = 4;
    localparam int F_PEND = 8;

    // reset values
    localparam logic [2:0] RST_OSR = 3'h3;
    localparam logic [1:0] RST_DIV = 2'h0;
endpackage

// file: rtl/dfp_top.sv
// decimation filter with per-channel phase offset, Avalon-MM registers
// Summary of operation
// - each bitstream feeds sinc3 and a fast-settling sinc1 path in parallel
// - after reset results come from the fast-settling path
// - after two conversions output moves to sinc3 until next reset
// - osr 64 to 1024: sinc3 decimates by osr, output goes straight on
// - osr 2048 and up: sinc3 by 1024 then sinc1 by 2 to 16
// - sinc3 is the cube of a length-N moving average, N the osr capped at 1024
// - enable, mux or gain change, or resync restart the filters
// - settling is 3*osr+48 clocks, or 6/10/18/34*1024+48 above 1024
// - results keep flowing while settling, not dropped; the status settled bit stays low meanwhile
// - output rate is modulator rate divided by osr
// - each channel holds a 10-bit signed phase in modulator cycles
// - each result sums osr samples except the first after a restart or phase write; zero phase aligns channels
// - phase range is -osr/2 to osr/2-1, capped at -512 to 511
// - out-of-range phase saturates to the nearest limit
// - phase settings move on the clock after the register write
// - fast-rate bit selects osr 64, the osr field gives 128 to 16384
// - modulator clock is main clock over 2, 4, 8 or 12, default 2
`timescale 1ns/1ps
module dfp_top import dfp_pkg::*; #(
    parameter int NCH = 3
) (
    input  wire logic           mclk_i,
    input  wire logic           rst_i,
    input  wire logic [7:0]     avs_address_i,
    input  wire logic           avs_read_i,
    input  wire logic           avs_write_i,
    input  wire logic [31:0]    avs_writedata_i,
    input  wire logic [3:0]     avs_byteenable_i,
    output logic [31:0]         avs_readdata_o,
    output logic                avs_waitrequest_o,
    input  wire logic [NCH-1:0] mod_bits_i,
    input  wire logic           resync_i,
    output logic                modulator_clock_o,
    output logic                sample_ready_n_o
);
    if (NCH < 1 || NCH > MAX_CH) begin : g_bad_nch
        $error("channel count out of range");
    end

    logic [2:0]                osr_code, next_osr_code;
    logic                      fast_rate, next_fast_rate;
    logic [1:0]                clk_div, next_clk_div;
    logic [NCH-1:0]            ch_en, next_ch_en;
    logic [NCH-1:0][PH_W-1:0]  phase, next_phase;
    logic [NCH-1:0][1:0]       mux, next_mux;
    logic [NCH-1:0][2:0]       gain, next_gain;
    logic                      ack, next_ack;
    logic [31:0]               rdata, next_rdata, rd_word, w, cw;
    logic                      wr, rsync;
    logic [NCH-1:0]            restart, next_restart;
    logic [3:0]                div_cnt, next_div_cnt, ratio;
    logic                      mclk_q, next_mclk_q, tick;
    logic [PH_W-1:0]           ref_cnt, next_ref_cnt, win_mask;
    logic [3:0]                ktot, k3;
    logic [2:0]                k1;
    logic [SET_W-1:0]          settle_tgt;
    logic [NCH-1:0]            settled, fast_all, valid_all;
    logic [NCH-1:0][RES_W-1:0] res_all;
    logic [NCH-1:0]            pending, next_pending, done;
    logic                      rdy_n, next_rdy_n, fire;

    // byte-lane merge of a write into a register image
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // osr split: sinc3 takes up to 1024, sinc1 the rest
    always_comb begin
        ktot = fast_rate ? LG_FAST : LG_BASE + {1'b0, osr_code};
        k3 = (ktot > LG_S3MAX) ? LG_S3MAX : ktot;
        k1 = 3'(ktot - k3);
        win_mask = PH_W'((11'h001 << k3) - 11'h001);
        if (k1 == 3'h0) begin
            settle_tgt = SET_W'(SET_S3MUL * (SET_W'(1) << k3)) + SET_TAIL;
        end else begin
            settle_tgt = SET_W'(((SET_ADD2 << k1) + SET_ADD2) * SET_BLK)
                         + SET_TAIL;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_word = 32'h0;
        if (avs_address_i == A_CLK) begin
            rd_word[F_OSR +: 3] = osr_code;
            rd_word[F_FAST] = fast_rate;
            rd_word[F_DIV +: 2] = clk_div;
            rd_word[F_EN +: NCH] = ch_en;
        end
        if (avs_address_i == A_STAT) begin
            rd_word[F_SETL +: NCH] = settled;
            rd_word[F_FSEL +: NCH] = fast_all;
            rd_word[F_PEND +: NCH] = pending;
        end
        for (int n = 0; n < NCH; n++) begin
            if (avs_address_i == A_CFG0 + 8'(n) * A_STEP) begin
                rd_word[F_PH +: PH_W] = phase[n];
                rd_word[F_MUX +: 2] = mux[n];
                rd_word[F_GAIN +: 3] = gain[n];
            end
            if (avs_address_i == A_RES0 + 8'(n) * A_STEP) begin
                rd_word[RES_W-1:0] = res_all[n];
            end
        end
    end

    // bus slave: one wait cycle, write lands when waitrequest is low
    always_comb begin
        next_ack = (avs_read_i | avs_write_i) & ~ack;
        next_rdata = rdata;
        next_osr_code = osr_code;
        next_fast_rate = fast_rate;
        next_clk_div = clk_div;
        next_ch_en = ch_en;
        next_phase = phase;
        next_mux = mux;
        next_gain = gain;
        next_restart = '0;
        rsync = resync_i;
        wr = avs_write_i & ack;
        w = 32'h0;
        cw = 32'h0;
        if (avs_read_i & ~ack) begin
            next_rdata = rd_word;
        end
        if (wr && avs_address_i == A_CLK) begin
            w = merge(rd_word, avs_writedata_i, avs_byteenable_i);
            next_osr_code = w[F_OSR +: 3];
            next_fast_rate = w[F_FAST];
            next_clk_div = w[F_DIV +: 2];
            next_ch_en = w[F_EN +: NCH];
        end
        if (wr && avs_address_i == A_RSYNC) begin
            w = merge(32'h0, avs_writedata_i, avs_byteenable_i);
            rsync = rsync | w[F_RSYNC];
        end
        for (int n = 0; n < NCH; n++) begin
            if (wr && avs_address_i == A_CFG0 + 8'(n) * A_STEP) begin
                cw = rd_word;
                w = merge(cw, avs_writedata_i, avs_byteenable_i);
                next_phase[n] = w[F_PH +: PH_W];
                next_mux[n] = w[F_MUX +: 2];
                next_gain[n] = w[F_GAIN +: 3];
                if (w[F_MUX +: 2] != mux[n] || w[F_GAIN +: 3] != gain[n]) begin
                    next_restart[n] = 1'b1;
                end
            end
        end
        next_restart = next_restart | (next_ch_en & ~ch_en) | {NCH{rsync}};
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdata <= 32'h0;
            osr_code <= RST_OSR;
            fast_rate <= 1'b0;
            clk_div <= RST_DIV;
            ch_en <= '0;
            phase <= '0;
            mux <= '0;
            gain <= '0;
            restart <= '0;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
            osr_code <= next_osr_code;
            fast_rate <= next_fast_rate;
            clk_div <= next_clk_div;
            ch_en <= next_ch_en;
            phase <= next_phase;
            mux <= next_mux;
            gain <= next_gain;
            restart <= next_restart;
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
    assign avs_readdata_o = rdata;

    // modulator divider and common window reference
    always_comb begin
        unique case (clk_div)
            2'h0: ratio = DIV_R0;
            2'h1: ratio = DIV_R1;
            2'h2: ratio = DIV_R2;
            2'h3: ratio = DIV_R3;
        endcase
        tick = (div_cnt >= ratio - 4'h1);
        next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
        next_mclk_q = (next_div_cnt < (ratio >> 1));    // 50% duty
        next_ref_cnt = ref_cnt;
        if (rsync) begin
            next_ref_cnt = '0;                          // realign all windows
        end else if (tick) begin
            next_ref_cnt = (ref_cnt + PH_W'(1)) & win_mask;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            div_cnt <= 4'h0;
            mclk_q <= 1'b0;
            ref_cnt <= '0;
        end else begin
            div_cnt <= next_div_cnt;
            mclk_q <= next_mclk_q;
            ref_cnt <= next_ref_cnt;
        end
    end

    assign modulator_clock_o = mclk_q;

    // per channel: clip phase, place window, track settling
    for (genvar n = 0; n < NCH; n++) begin : g_ch
        dfp_chan_if cif ();
        logic signed [PH_W:0] ph, half, clip;
        logic [SET_W-1:0]     scnt, next_scnt;

        always_comb begin
            ph = $signed({phase[n][PH_W-1], phase[n]});
            half = $signed(11'h001 << (k3 - 4'h1));
            clip = ph;
            if (ph < -half) begin
                clip = -half;
            end else if (ph > half - 11'sh001) begin
                clip = half - 11'sh001;
            end
            next_scnt = scnt;
            if (restart[n] | ~ch_en[n]) begin
                next_scnt = '0;
            end else if (scnt < settle_tgt) begin
                next_scnt = scnt + SET_W'(1);
            end
        end

        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                scnt <= '0;
            end else begin
                scnt <= next_scnt;
            end
        end

        assign cif.tick = tick;
        assign cif.bit_in = mod_bits_i[n];
        assign cif.restart = restart[n] | ~ch_en[n];
        // window shifts by the clipped phase
        assign cif.win_end = tick & (ref_cnt == (clip[PH_W-1:0] & win_mask));
        assign cif.k3 = k3;
        assign cif.k1 = k1;
        assign settled[n] = (scnt >= settle_tgt);
        assign fast_all[n] = cif.fast_sel;
        assign valid_all[n] = cif.valid;
        assign res_all[n] = cif.result;

        dfp_chan u_chan (
            .mclk_i (mclk_i),
            .rst_i  (rst_i),
            .cif    (cif.chan)
        );
    end

    // ready strobe falls once every enabled channel has a fresh result
    always_comb begin
        done = (pending | valid_all) & ch_en;
        fire = (ch_en != '0) && (done == ch_en);
        next_pending = fire ? '0 : done;
        next_rdy_n = ~fire;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pending <= '0;
            rdy_n <= 1'b1;
        end else begin
            pending <= next_pending;
            rdy_n <= next_rdy_n;
        end
    end

    assign sample_ready_n_o = rdy_n;
endmodule // dfp_top

// file: tb/dfp_mod_src.sv
// modulator bitstream model: steady ones, zeros or alternating per channel
`timescale 1ns/1ps
module dfp_mod_src import dfp_pkg::*; #(
    parameter int NCH = 3
) (
    input  wire logic           mclk_i,
    input  wire logic           rst_i,
    input  wire logic           modulator_clock_i,
    input  wire logic [NCH-1:0] ones_i,
    input  wire logic [NCH-1:0] alt_i,
    output logic [NCH-1:0]      bits_o
);
    logic prev;
    logic ph;

    // one change per modulator cycle, so any even window holds half ones
    always_ff @(posedge mclk_i) begin
        prev <= modulator_clock_i;
        ph   <= rst_i ? 1'b0 : ph ^ (modulator_clock_i & ~prev);
    end
    assign bits_o = (ones_i & ~alt_i) | (alt_i & {NCH{ph}});
endmodule // dfp_mod_src

// file: tb/dfp_top_asserts.sv
// port-level assertions for the decimation filter top
`timescale 1ns/1ps
module dfp_top_asserts import dfp_pkg::*; #(
    parameter int NCH = 3
) (
    input wire logic           mclk_i,
    input wire logic           rst_i,
    input wire logic [7:0]     avs_address_i,
    input wire logic           avs_read_i,
    input wire logic           avs_write_i,
    input wire logic [31:0]    avs_writedata_i,
    input wire logic [3:0]     avs_byteenable_i,
    input wire logic [31:0]    avs_readdata_o,
    input wire logic           avs_waitrequest_o,
    input wire logic [NCH-1:0] mod_bits_i,
    input wire logic           resync_i,
    input wire logic           modulator_clock_o,
    input wire logic           sample_ready_n_o
);
    logic clk_wr;
    logic cfg_wr;
    logic ever_en;
    logic next_cfg_wr;
    logic next_ever_en;

    // clock register writes land where waitrequest is low
    assign clk_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == A_CLK;

    // remember clock register writes and any channel enable since reset
    always_comb begin
        next_cfg_wr  = cfg_wr | clk_wr;
        next_ever_en = ever_en | (clk_wr && avs_byteenable_i[1]
                       && avs_writedata_i[F_EN +: NCH] != '0);
    end
    always_ff @(posedge mclk_i) begin
        cfg_wr  <= rst_i ? 1'b0 : next_cfg_wr;
        ever_en <= rst_i ? 1'b0 : next_ever_en;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_wait_first: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o)
        else $error("waitrequest low in first request cycle");
    a_wait_one: assert property ((avs_read_i | avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("more than one wait cycle");
    a_wait_idle: assert property (!(avs_read_i | avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest high without request");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i == 8'h0C |-> avs_readdata_o == '0)
        else $error("unmapped read not zero");
    a_reset_outs: assert property ($fell(rst_i) |-> !modulator_clock_o
        && sample_ready_n_o && avs_readdata_o == '0)
        else $error("outputs not at reset values");
    a_div_two: assert property ($rose(modulator_clock_o) && !cfg_wr && !clk_wr
        |=> $fell(modulator_clock_o))
        else $error("default divider not two");
    a_no_ready: assert property (!ever_en |-> sample_ready_n_o)
        else $error("ready strobe with no channel enabled");
    a_ready_gap: assert property (!sample_ready_n_o |=> sample_ready_n_o [*8])
        else $error("ready strobe too long or too close");
endmodule // dfp_top_asserts

bind dfp_top dfp_top_asserts #(.NCH(NCH)) dfp_top_asserts_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .mod_bits_i(mod_bits_i), .resync_i(resync_i),
    .modulator_clock_o(modulator_clock_o), .sample_ready_n_o(sample_ready_n_o));

// file: tb/dfp_top_tb_top.sv
// self-checking bench for the decimation filter top
`timescale 1ns/1ps
module dfp_top_tb_top import dfp_pkg::*;;
    localparam int NCH = 3;
    logic           mclk_i = 1'b0;
    logic           rst_i = 1'b1;
    logic [7:0]     avs_address_i = '0;
    logic           avs_read_i = 1'b0;
    logic           avs_write_i = 1'b0;
    logic [31:0]    avs_writedata_i = '0;
    logic [3:0]     avs_byteenable_i = 4'hF;
    logic [31:0]    avs_readdata_o;
    logic           avs_waitrequest_o;
    logic [NCH-1:0] mod_bits_i;
    logic           resync_i = 1'b0;
    logic           modulator_clock_o;
    logic           sample_ready_n_o;
    logic [NCH-1:0] ones = 3'h1;
    logic [NCH-1:0] alt = 3'h4;
    int             num_errors = 0;
    int             n_compared = 0;
    int             cyc = 0;

    always #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) cyc <= cyc + 1;

    dfp_top #(.NCH(NCH)) dfp_top_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .mod_bits_i(mod_bits_i), .resync_i(resync_i),
        .modulator_clock_o(modulator_clock_o), .sample_ready_n_o(sample_ready_n_o));
    dfp_mod_src #(.NCH(NCH)) dfp_mod_src_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .modulator_clock_i(modulator_clock_o),
        .ones_i(ones), .alt_i(alt), .bits_o(mod_bits_i));

    task automatic close_out();
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus cycle, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= !w;
        avs_write_i <= w;
        // waitrequest is looked at on the rising edge only; a hang is left to the watchdog
        do begin
            @(posedge mclk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, '0, q);
        chk(nm, e, q & m);
    endtask
    // cycle stamp of the k-th ready strobe from now
    task automatic wait_rdy(input int k, output int t);
        for (int i = 0; i < k; i++) begin
            do begin
                @(negedge mclk_i);
            end while (sample_ready_n_o !== 1'b0);
            t = cyc;
        end
    endtask
    task automatic mod_per(output int p);
        int t0;
        @(posedge modulator_clock_o);
        @(posedge modulator_clock_o);
        t0 = cyc;
        @(posedge modulator_clock_o);
        p = cyc - t0;
    endtask

    // a hang counts as a mismatch
    initial begin
        repeat (40000) @(posedge mclk_i);
        num_errors++;
        close_out();
    end

    initial begin
        int t0;
        int t1;
        int p;
        automatic int ph[3] = '{100, -100, 5};
        automatic int ex[3] = '{31, -32, 5};
        automatic logic [3:0] rt[4] = '{DIV_R0, DIV_R1, DIV_R2, DIV_R3};
        automatic logic [23:0] rs[3] = '{24'h7FFFFF, 24'h800000, 24'h000000};
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd_chk("clock_ctrl", A_CLK, 32'hFFFFFFFF, 32'h00000003);
        wr(8'h0C, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h00000000);
        for (int k = 0; k < 4; k++) begin
            wr(A_CLK, 32'h3 | (32'(k) << F_DIV));
            mod_per(p);
            chk("mod_period", {28'h0, rt[k]}, 32'(p));
        end
        // fast rate, divide by two, three channels on
        wr(A_CLK, 32'h0708);
        wait_rdy(1, t0);
        rd_chk("status_early", A_STAT, 32'h77, 32'h70);
        wait_rdy(1, t1);
        chk("frame_gap", 32'(64 * DIV_R0), 32'(t1 - t0));
        wait_rdy(2, t1);
        rd_chk("status_late", A_STAT, 32'h77, 32'h07);
        for (int c = 0; c < 3; c++) begin
            rd_chk("result", A_RES0 + 8'(c) * A_STEP, 32'hFFFFFF, {8'h0, rs[c]});
        end
        @(posedge mclk_i);
        resync_i <= 1'b1;
        @(posedge mclk_i);
        resync_i <= 1'b0;
        rd_chk("resync", A_STAT, 32'h77, 32'h00);
        wait_rdy(3, t1);
        wr(A_CFG0 + A_STEP, 32'h1000);
        rd_chk("gain_restart", A_STAT, 32'h7, 32'h5);
        // only channel zero on; ready moves by two clocks per phase tick
        wr(A_CLK, 32'h0108);
        wait_rdy(2, t0);
        for (int i = 0; i < 3; i++) begin
            wr(A_CFG0, 32'(ph[i]) & 32'h3FF);
            wait_rdy(3, t1);
            chk("phase", 32'h0, 32'(((t1 - t0 - 2 * ex[i]) % 128 + 128) % 128));
        end
        wr(A_CLK, 32'h8); // standby before the osr change
        wr(A_CLK, 32'h4);
        wr(A_CLK, 32'h0104);
        wait_rdy(2, t0);
        wait_rdy(1, t1);
        chk("cascade_gap", 32'h1000, 32'(t1 - t0));
        wait_rdy(2, t1);
        rd_chk("cascade_res", A_RES0, 32'hFFFFFF, 32'h7FFFFF);
        close_out();
    end
endmodule // dfp_top_tb_top
